// ===== logic/pit_params.svh
// constants of the prescaled interval timer: reset values, widths, clock figures
// assumes inclusion by bare name from the package and the design modules
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH

// ============================================================
// widths
`define PIT_CNT_W        8
`define PIT_STATE_W      2

// ============================================================
// reset values of reload registers and counters, and the zero and step constants
`define PIT_PRE_RESET    8'hFF
`define PIT_CNT_RESET    8'hFF
`define PIT_CNT_ZERO     8'h00
`define PIT_CNT_ONE      8'h01

// ============================================================
// count source
`define PIT_CLOCK_HZ     25000000
`define PIT_SRC_DIV      2
`define PIT_PHASE_RESET  1'b0
`define PIT_PHASE_TICK   1'b1

`endif

// ===== logic/pit_pkg.sv
// types shared by the prescaled interval timer modules
// assumes pit_params.svh sits on the include path
`default_nettype none
`include "pit_params.svh"

package pit_pkg;

	typedef logic [`PIT_CNT_W-1:0] pit_count_t;

	// run control of the count
	typedef enum logic [`PIT_STATE_W-1:0] {
		PIT_IDLE = 2'b00,
		PIT_ARM  = 2'b01,
		PIT_RUN  = 2'b10,
		PIT_HALT = 2'b11
	} pit_run_e;

endpackage : pit_pkg

`default_nettype wire

// ===== logic/pit_stage.sv
// one down-counting stage with its reload register
// assumes pit_pkg compiled first; all inputs from the same clock
`timescale 1ns/1ps
`default_nettype none
`include "pit_params.svh"

module pit_stage
	import pit_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       clk_en,
	// control
	input  wire logic       tick,
	input  wire logic       reload_now,
	input  wire logic       write_through,
	// software write
	input  wire logic       wr,
	input  wire pit_count_t wr_data,
	// state
	output pit_count_t      value,
	output pit_count_t      reload_value,
	output logic            at_zero
);

	// ============================================================
	// next values
	pit_count_t next_value;
	pit_count_t next_reload_value;

	always_comb begin
		next_reload_value = reload_value;
		if (wr) begin
			next_reload_value = wr_data;
		end
		next_value = value;
		if (wr && write_through) begin
			next_value = wr_data;
		end else if (reload_now) begin
			// a write in the same cycle is taken at once
			next_value = next_reload_value;
		end else if (tick) begin
			next_value = value - `PIT_CNT_ONE;
		end
	end

	// ============================================================
	// registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			value        <= `PIT_CNT_RESET;
			reload_value <= `PIT_CNT_RESET;
		end else if (clk_en) begin
			value        <= next_value;
			reload_value <= next_reload_value;
		end
	end

	assign at_zero = (value == `PIT_CNT_ZERO);

endmodule // pit_stage

`default_nettype wire

// ===== logic/pit_timer.sv
// prescaled interval timer in timer mode: count source, two stages, run control
// assumes software control arrives as plain same-clock inputs, no register bus
`timescale 1ns/1ps
`default_nettype none
`include "pit_params.svh"

module pit_timer
	import pit_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       clk_en,
	// run control
	input  wire logic       count_start,
	input  wire logic       force_stop,
	input  wire logic       write_control,
	// prescaler reload write
	input  wire logic       prescaler_write,
	input  wire pit_count_t prescaler_write_data,
	// counter reload write
	input  wire logic       counter_write,
	input  wire pit_count_t counter_write_data,
	// status
	output logic            count_status,
	output logic            half_oscillator_clock,
	output logic            timer_irq,
	// stage contents
	output pit_count_t      prescaler_reload_value,
	output pit_count_t      counter_reload_value,
	output pit_count_t      prescaler_value,
	output pit_count_t      counter_value
);

	// ============================================================
	// count source
	// the system clock stands for the oscillator; the source is an
	// enable every second edge, so no derived clock net exists
	// clock enable low freezes the phase too, so a frozen timer
	// resumes on the same half of the source period
	logic next_half_oscillator_clock;
	logic src_tick;

	always_comb begin
		next_half_oscillator_clock = ~half_oscillator_clock;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			half_oscillator_clock <= `PIT_PHASE_RESET;
		end else if (clk_en) begin
			half_oscillator_clock <= next_half_oscillator_clock;
		end
	end

	// one tick per two enabled clocks gives the halved count source
	assign src_tick = (half_oscillator_clock == `PIT_PHASE_TICK);

	// ============================================================
	// run control
	// start and stop act on count source edges, so the status flag
	// lags the start level by two or three clocks
	pit_run_e run_state;
	pit_run_e next_run_state;
	logic     next_count_status;
	logic     stop_hold;
	logic     next_stop_hold;
	logic     start_ok;

	// a forced stop holds off the count until start has been dropped,
	// so a start level left high cannot restart the timer by itself
	assign start_ok = count_start && !stop_hold;

	always_comb begin
		next_run_state    = run_state;
		next_count_status = count_status;
		next_stop_hold    = stop_hold;
		// the hold clears on any enabled clock that sees start low and no forced stop
		if (!count_start) begin
			next_stop_hold = 1'b0;
		end
		// a forced stop wins over every run transition
		if (force_stop) begin
			next_run_state    = PIT_IDLE;
			next_count_status = 1'b0;
			next_stop_hold    = 1'b1;
		end else begin
			case (run_state)
				PIT_IDLE: begin
					if (start_ok) begin
						next_run_state = PIT_ARM;
					end
				end
				PIT_ARM: begin
					// status rises on a source tick, two clocks ahead of the first count
					if (!start_ok) begin
						next_run_state = PIT_IDLE;
					end else if (src_tick) begin
						next_run_state    = PIT_RUN;
						next_count_status = 1'b1;
					end
				end
				PIT_RUN: begin
					// the count stops at once; the status waits for the next tick
					if (!start_ok) begin
						next_run_state = PIT_HALT;
					end
				end
				PIT_HALT: begin
					// start back before the next tick resumes the count where it
					// stopped; the stages are not reloaded
					if (start_ok) begin
						next_run_state = PIT_RUN;
					end else if (src_tick) begin
						next_run_state    = PIT_IDLE;
						next_count_status = 1'b0;
					end
				end
				default: begin
					// unused code falls back to a clean stop
					next_run_state    = PIT_IDLE;
					next_count_status = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			run_state    <= PIT_IDLE;
			count_status <= 1'b0;
			stop_hold    <= 1'b0;
		end else if (clk_en) begin
			run_state    <= next_run_state;
			count_status <= next_count_status;
			stop_hold    <= next_stop_hold;
		end
	end

	// ============================================================
	// stage chaining
	logic counting;
	logic pre_zero;
	logic cnt_zero;
	logic pre_tick;
	logic cnt_tick;
	logic underflow;
	logic write_through;

	// counting only in the run state: the hold state keeps the values
	assign counting  = (run_state == PIT_RUN);
	assign pre_tick  = counting && src_tick;
	// main stage moves once per full prescaler cycle
	assign cnt_tick  = pre_tick && pre_zero;
	// (p+1) source ticks per prescaler cycle, (c+1) of those per period,
	// two clocks per source tick
	assign underflow = cnt_tick && cnt_zero;
	// while stopped nothing is counting, so writes always go through;
	// while counting, control high leaves the running value alone
	assign write_through = !write_control || !counting;

	// ============================================================
	// stage reloads
	// the prescaler starts over at each full cycle and the counter at each
	// period end; a forced stop puts both back to their reload values, so
	// the next start always begins a full period
	logic pre_reload;
	logic cnt_reload;

	assign pre_reload = cnt_tick || force_stop;
	assign cnt_reload = underflow || force_stop;

	pit_stage u_prescaler (
		.clock         (clock),
		.rst           (rst),
		.clk_en        (clk_en),
		.tick          (pre_tick),
		.reload_now    (pre_reload),
		.write_through (write_through),
		.wr            (prescaler_write),
		.wr_data       (prescaler_write_data),
		.value         (prescaler_value),
		.reload_value  (prescaler_reload_value),
		.at_zero       (pre_zero)
	);

	pit_stage u_counter (
		.clock         (clock),
		.rst           (rst),
		.clk_en        (clk_en),
		.tick          (cnt_tick),
		.reload_now    (cnt_reload),
		.write_through (write_through),
		.wr            (counter_write),
		.wr_data       (counter_write_data),
		.value         (counter_value),
		.reload_value  (counter_reload_value),
		.at_zero       (cnt_zero)
	);

	// ============================================================
	// interrupt request
	// registered so the pulse is glitch free; a one-clock pulse per
	// period, any latching belongs to the interrupt controller;
	// clock enable low stretches the pulse along with the rest of the state
	logic next_timer_irq;

	always_comb begin
		next_timer_irq = underflow;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			timer_irq <= 1'b0;
		end else if (clk_en) begin
			timer_irq <= next_timer_irq;
		end
	end

endmodule // pit_timer

`default_nettype wire

// ===== verif/pit_timer_props.sv
// assertions on the prescaled interval timer ports
// assumes binding onto pit_timer; one clock domain
`timescale 1ns/1ps
`default_nettype none

module pit_timer_props
	import pit_pkg::*;
(
	// control
	input wire logic       clock, rst, clk_en, count_start, force_stop, write_control,
	input wire logic       prescaler_write, counter_write,
	input wire pit_count_t prescaler_write_data, counter_write_data,
	// status and stage contents
	input wire logic       count_status, half_oscillator_clock, timer_irq,
	input wire pit_count_t prescaler_reload_value, counter_reload_value, prescaler_value, counter_value
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// =====
	// helpers: a clean tick with no write that could override it
	logic tick_run;
	logic pre_zero;
	logic cnt_zero;
	logic start_prev;
	// the hold state looks like counting at the ports; the start level seen
	// at the last enabled edge tells the two apart
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			start_prev <= 1'b0;
		end else if (clk_en) begin
			start_prev <= count_start && !force_stop;
		end
	end
	assign tick_run = clk_en && half_oscillator_clock && count_status && start_prev && !force_stop
		&& !prescaler_write && !counter_write;
	assign pre_zero = prescaler_value == 8'h00;
	assign cnt_zero = counter_value == 8'h00;

	// =====
	// assertions
	src_toggle_a: assert property (clk_en |=> half_oscillator_clock != $past(half_oscillator_clock))
		else $error("count source did not toggle");
	pre_dec_a: assert property (tick_run && !pre_zero |=> prescaler_value == $past(prescaler_value) - 8'h01)
		else $error("prescaler did not step");
	cnt_step_a: assert property (tick_run && pre_zero && !cnt_zero |=>
		counter_value == $past(counter_value) - 8'h01 && prescaler_value == prescaler_reload_value)
		else $error("counter did not step");
	wrap_load_a: assert property (tick_run && pre_zero && cnt_zero |=>
		prescaler_value == prescaler_reload_value && counter_value == counter_reload_value)
		else $error("no reload on underflow");
	wrap_irq_a: assert property (tick_run && pre_zero && cnt_zero |-> ##[1:2] timer_irq)
		else $error("no request on underflow");
	irq_pulse_a: assert property (timer_irq && clk_en |=> !timer_irq)
		else $error("request longer than one clock");
	pre_through_a: assert property (clk_en && prescaler_write && !write_control && !force_stop |=>
		prescaler_value == $past(prescaler_write_data) && prescaler_reload_value == $past(prescaler_write_data))
		else $error("prescaler write not through");
	cnt_through_a: assert property (clk_en && counter_write && !write_control && !force_stop |=>
		counter_value == $past(counter_write_data) && counter_reload_value == $past(counter_write_data))
		else $error("counter write not through");
	stop_reload_a: assert property (clk_en && force_stop |=> !count_status
		&& prescaler_value == prescaler_reload_value && counter_value == counter_reload_value)
		else $error("forced stop did not reload");
	freeze_hold_a: assert property (!clk_en |=> $stable(prescaler_value) && $stable(counter_value)
		&& $stable(half_oscillator_clock) && $stable(count_status) && $stable(timer_irq))
		else $error("state moved while clock enable low");
endmodule // pit_timer_props

bind pit_timer pit_timer_props props (.clock(clock), .rst(rst), .clk_en(clk_en), .count_start(count_start),
	.force_stop(force_stop), .write_control(write_control), .prescaler_write(prescaler_write),
	.counter_write(counter_write), .prescaler_write_data(prescaler_write_data),
	.counter_write_data(counter_write_data), .count_status(count_status),
	.half_oscillator_clock(half_oscillator_clock), .timer_irq(timer_irq),
	.prescaler_reload_value(prescaler_reload_value), .counter_reload_value(counter_reload_value),
	.prescaler_value(prescaler_value), .counter_value(counter_value));

`default_nettype wire

// ===== verif/pit_timer_tb.sv
// self-checking bench for the prescaled interval timer
// assumes pit_pkg and pit_timer compiled first; inputs move at falling edge
`timescale 1ns/1ps
`default_nettype none

module pit_timer_tb
	import pit_pkg::*;
;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       clk_en = 1'b1;
	logic       count_start = 1'b0;
	logic       force_stop = 1'b0;
	logic       write_control = 1'b0;
	logic       prescaler_write = 1'b0;
	logic       counter_write = 1'b0;
	pit_count_t prescaler_write_data = 8'h00;
	pit_count_t counter_write_data = 8'h00;
	logic       count_status;
	logic       half_oscillator_clock;
	logic       timer_irq;
	pit_count_t prescaler_reload_value;
	pit_count_t counter_reload_value;
	pit_count_t prescaler_value;
	pit_count_t counter_value;
	int         mismatches = 0;
	int         comparisons = 0;
	pit_count_t ptab [5] = '{8'h00, 8'h04, 8'h00, 8'h01, 8'hC7};
	pit_count_t ctab [5] = '{8'h00, 8'h00, 8'h05, 8'h02, 8'h31};

	always #20 clock = ~clock;

	pit_timer dut (.clock(clock), .rst(rst), .clk_en(clk_en), .count_start(count_start), .force_stop(force_stop),
		.write_control(write_control), .prescaler_write(prescaler_write),
		.prescaler_write_data(prescaler_write_data), .counter_write(counter_write),
		.counter_write_data(counter_write_data), .count_status(count_status),
		.half_oscillator_clock(half_oscillator_clock), .timer_irq(timer_irq),
		.prescaler_reload_value(prescaler_reload_value), .counter_reload_value(counter_reload_value),
		.prescaler_value(prescaler_value), .counter_value(counter_value));

	// =====
	// shared tasks
	task automatic check(input logic ok, input string what);
		comparisons++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t ns: %s", $time, what);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic write_both(input pit_count_t p, input pit_count_t c);
		prescaler_write = 1'b1;
		counter_write = 1'b1;
		prescaler_write_data = p;
		counter_write_data = c;
		step(1);
		prescaler_write = 1'b0;
		counter_write = 1'b0;
	endtask

	// n is the number of clocks up to the next request
	task automatic wait_irq(output int n);
		n = 0;
		do begin
			step(1);
			n++;
			if (n > 30000) begin
				check(1'b0, "no timer request");
				conclude();
			end
		end while (timer_irq !== 1'b1);
	endtask

	task automatic stop_timer();
		count_start = 1'b0;
		force_stop = 1'b1;
		step(1);
		force_stop = 1'b0;
		check(count_status === 1'b0, "status after stop");
		check(prescaler_value === prescaler_reload_value, "reload on stop");
		step(1);
	endtask

	// =====
	// scenarios
	task automatic test_reset();
		logic ph;
		check(prescaler_value === 8'hFF && counter_reload_value === 8'hFF && count_status === 1'b0, "reset");
		check(counter_value === 8'hFF && prescaler_reload_value === 8'hFF && timer_irq === 1'b0, "reset stages");
		check(half_oscillator_clock === 1'b0, "reset phase");
		ph = half_oscillator_clock;
		step(1);
		check(half_oscillator_clock === ~ph, "source phase");
		$display("test reset done");
	endtask

	task automatic test_write_modes();
		stop_timer();
		write_both(8'h03, 8'h05);
		count_start = 1'b1;
		step(20);
		write_control = 1'b1;
		write_both(8'h09, 8'h09);
		check(prescaler_reload_value === 8'h09 && counter_reload_value === 8'h09, "reload only write");
		check(counter_value <= 8'h05, "running value kept");
		write_control = 1'b0;
		step(1);
		write_both(8'h07, 8'h04);
		check(prescaler_value === 8'h07 && counter_value === 8'h04, "write through");
		check(count_status === 1'b1, "still counting");
		$display("test write modes done");
	endtask

	task automatic test_control();
		pit_count_t pv;
		pit_count_t cv;
		logic       ph;
		count_start = 1'b0;
		step(1);
		count_start = 1'b1;
		step(1);
		check(count_status === 1'b1, "resume from hold");
		count_start = 1'b0;
		step(1);
		pv = prescaler_value;
		cv = counter_value;
		step(3);
		check(count_status === 1'b0 && prescaler_value === pv && counter_value === cv, "stop on start low");
		count_start = 1'b1;
		step(4);
		check(count_status === 1'b1, "restart");
		force_stop = 1'b1;
		step(1);
		force_stop = 1'b0;
		step(4);
		check(count_status === 1'b0, "start refused after forced stop");
		count_start = 1'b0;
		step(1);
		count_start = 1'b1;
		step(4);
		check(count_status === 1'b1, "start after release");
		clk_en = 1'b0;
		ph = half_oscillator_clock;
		pv = prescaler_value;
		cv = counter_value;
		step(5);
		check(half_oscillator_clock === ph && prescaler_value === pv && counter_value === cv, "frozen by clock enable");
		clk_en = 1'b1;
		step(2);
		check(prescaler_value !== pv && count_status === 1'b1, "counts after freeze");
		$display("test control done");
	endtask

	task automatic test_period(input pit_count_t p, input pit_count_t c);
		int n;
		stop_timer();
		write_both(p, c);
		check(prescaler_value === p && counter_value === c, "stopped write");
		count_start = 1'b1;
		wait_irq(n);
		wait_irq(n);
		check(n == 2 * (p + 1) * (c + 1), "timer period");
		$display("test period %0d %0d done", p, c);
	endtask

	initial begin
		step(10);
		rst = 1'b0;
		test_reset();
		test_write_modes();
		test_control();
		for (int i = 0; i < 5; i++)
			test_period(ptab[i], ctab[i]);
		conclude();
	end
endmodule // pit_timer_tb

`default_nettype wire
